// ### logic/rcpd_dimmer_top.sv
// rgb channel pwm dimmer: colour and intensity registers, 12 phased pwm sinks
// assumes register writes arrive already decoded from the serial bus,
// synchronous to clk_sys_in
`timescale 1ns/10ps
`default_nettype none
module rcpd_dimmer_top
  import rcpd_pkg::*;
#(
  parameter int unsigned PSM_DEGLITCH_CYCLES = PSM_CYCLES
)
(
  input  wire logic        clk_sys_in,
  input  wire logic        reset_n_in,
  input  wire logic        enable_in,
  input  wire logic [1:0]  hw_address_pins_in,
  input  wire logic        log_scale_en_in,
  input  wire logic        dither_en_in,
  input  wire logic        power_save_en_in,
  input  wire logic        reg_write_in,
  input  wire logic [4:0]  reg_index_in,
  input  wire logic [7:0]  reg_wdata_in,
  output logic      [11:0] sink_output_out,
  output logic      [7:0]  reg_rdata_out,
  output logic      [6:0]  bus_address_out,
  output logic             iface_reset_out,
  output logic             power_save_out
);

  // ------------------------------------------------------------------
  // register file
  // ------------------------------------------------------------------
  logic [7:0]     channel_color_value_reg    [NUM_CH];
  logic [7:0]     module_intensity_value_reg [NUM_MOD];
  logic [11:0]    duty_act_reg               [NUM_CH];
  logic [11:0]    duty_calc                  [NUM_CH];
  logic [11:0]    sink_next;
  logic [11:0]    zero_vec;
  logic           clear_all;
  logic           is_int;
  logic           is_col;
  logic           is_stat;
  logic [4:0]     col_off;
  logic [3:0]     col_idx;
  logic [7:0]     rd_mux;
  rcpd_state_type state_reg;
  rcpd_state_type state_next;

  // registers clear in reset and while the enable pin is low
  assign clear_all = !reset_n_in || !enable_in;
  assign is_int    = (reg_index_in < IDX_COL_BASE);
  assign is_col    = (reg_index_in >= IDX_COL_BASE) && (reg_index_in < IDX_COL_END);
  assign is_stat   = (reg_index_in == IDX_STATUS);
  assign col_off   = reg_index_in - IDX_COL_BASE;
  assign col_idx   = col_off[3:0];

  // read mux, unmapped index reads zero
  assign rd_mux = is_int  ? module_intensity_value_reg[reg_index_in[1:0]] :
                  is_col  ? channel_color_value_reg[col_idx] :
                  is_stat ? {6'h00, state_reg == ST_PSAVE, state_reg == ST_NORMAL} :
                            8'h00;

  // colour and intensity writes
  always_ff @(posedge clk_sys_in)
  begin
    for (int i = 0; i < NUM_CH; i++)
    begin
      if (clear_all)
        channel_color_value_reg[i] <= COLOR_RST;
      else if (reg_write_in && is_col && col_idx == 4'(i))
        channel_color_value_reg[i] <= reg_wdata_in;
    end
    for (int m = 0; m < NUM_MOD; m++)
    begin
      if (clear_all)
        module_intensity_value_reg[m] <= INTENSITY_RST;
      else if (reg_write_in && is_int && reg_index_in[1:0] == 2'(m))
        module_intensity_value_reg[m] <= reg_wdata_in;
    end
  end

  // registered read data
  always_ff @(posedge clk_sys_in)
  begin
    if (!reset_n_in)
      reg_rdata_out <= 8'h00;
    else
      reg_rdata_out <= rd_mux;
  end

  // ------------------------------------------------------------------
  // oscillator tick and pwm period counter
  // ------------------------------------------------------------------
  logic [3:0] div_reg;
  logic [8:0] cnt_reg;
  logic [2:0] frame_reg;
  logic       tick;
  logic       period_end;

  assign tick       = (div_reg == TICK_LAST);
  assign period_end = tick && (cnt_reg == PWM_LAST);

  // 512 ticks of about 15.6 MHz (clk_sys_in / 8) give a period near 30.5 kHz
  always_ff @(posedge clk_sys_in)
  begin
    if (clear_all)
    begin
      div_reg   <= 4'h0;
      cnt_reg   <= 9'h000;
      frame_reg <= 3'h0;
    end
    else
    begin
      div_reg <= tick ? 4'h0 : div_reg + 4'h1;
      if (tick)
        cnt_reg <= cnt_reg + 9'h001;
      if (period_end)
        frame_reg <= frame_reg + 3'h1;
    end
  end

  // ------------------------------------------------------------------
  // per-channel duty and phase generation
  // ------------------------------------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++)
    begin : g_ch
      logic [7:0]  inten;
      logic [7:0]  curve;
      logic [15:0] prod;
      logic [9:0]  wid;
      logic [9:0]  start;
      logic [9:0]  cnt10;
      logic        on;

      assign inten = module_intensity_value_reg[ch / 3];
      // curve on intensity only, colour passes straight through
      assign curve = log_scale_en_in ? rcpd_log_curve(inten) : inten;
      assign prod  = 16'(channel_color_value_reg[ch] * ({1'b0, curve} + 9'h001));
      assign duty_calc[ch] = prod[15:4];
      // dither lengthens frac of every eight pulses by one step
      assign wid   = {1'b0, duty_act_reg[ch][11:3]}
                   + 10'(dither_en_in && (duty_act_reg[ch][2:0] > frame_reg));
      assign start = (PWM_STEPS - wid) >> 1;
      assign cnt10 = {1'b0, cnt_reg};
      assign zero_vec[ch] = (duty_act_reg[ch] == 12'h000);

      // phase group by channel position
      if (ch % 3 == 0)
      begin : g_lead
        assign on = cnt10 < wid;
      end
      else if (ch % 3 == 1)
      begin : g_mid
        assign on = (cnt10 >= start) && (cnt10 < start + wid);
      end
      else
      begin : g_trail
        assign on = cnt10 >= (PWM_STEPS - wid);
      end

      assign sink_next[ch] = on && (state_reg != ST_SHUT);

      // active duty reloads only at the period boundary
      always_ff @(posedge clk_sys_in)
      begin
        if (clear_all)
          duty_act_reg[ch] <= 12'h000;
        else if (period_end)
          duty_act_reg[ch] <= duty_calc[ch];
      end
    end
  endgenerate

  // sink outputs straight from flops
  always_ff @(posedge clk_sys_in)
  begin
    if (clear_all)
      sink_output_out <= 12'h000;
    else
      sink_output_out <= sink_next;
  end

  // ------------------------------------------------------------------
  // power save deglitch, interface reset and address capture
  // ------------------------------------------------------------------
  logic [21:0] off_cnt_reg;
  logic        all_off;
  logic        off_done;

  assign all_off  = &zero_vec;
  assign off_done = (off_cnt_reg == 22'(PSM_DEGLITCH_CYCLES - 1));

  // mode selection
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_SHUT:
        state_next = ST_NORMAL;
      ST_NORMAL:
        if (off_done && power_save_en_in)
          state_next = ST_PSAVE;
      ST_PSAVE:
        if (reg_write_in || !all_off || !power_save_en_in)
          state_next = ST_NORMAL;
      default:
        state_next = ST_SHUT;
    endcase
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (clear_all)
      state_reg <= ST_SHUT;
    else
      state_reg <= state_next;
  end

  // all-off duration counter
  always_ff @(posedge clk_sys_in)
  begin
    if (clear_all || !all_off || !power_save_en_in || state_reg != ST_NORMAL)
      off_cnt_reg <= OFF_CNT_RST;
    else if (!off_done)
      off_cnt_reg <= off_cnt_reg + 22'h000001;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (clear_all)
      power_save_out <= 1'b0;
    else
      power_save_out <= (state_next == ST_PSAVE);
  end

  // interface reset one cycle after enable falls, far inside 3 us
  always_ff @(posedge clk_sys_in)
  begin
    if (!reset_n_in)
      iface_reset_out <= 1'b1;
    else
      iface_reset_out <= !enable_in;
  end

  // address tracks pins while disabled and on the first cycle after enable rises, then frozen
  always_ff @(posedge clk_sys_in)
  begin
    if (!reset_n_in)
      bus_address_out <= 7'h00;
    else if (!enable_in || iface_reset_out)
      bus_address_out <= {ADDR_BASE, hw_address_pins_in};
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);

  chk_intensity_reset: assert property (!enable_in |=> module_intensity_value_reg[0] == 8'hff)
    else $error("intensity not back at full scale");
  chk_color_write: assert property ((enable_in && reg_write_in && reg_index_in == 5'h05) ##1 enable_in
                                    |-> channel_color_value_reg[1] == $past(reg_wdata_in))
    else $error("colour write lost");
  chk_full_linear: assert property ((!log_scale_en_in && module_intensity_value_reg[0] == 8'hff
                                     && channel_color_value_reg[0] == 8'hff) |-> duty_calc[0] == 12'hff0)
    else $error("full colour and intensity wrong duty");
  chk_log_color_kept: assert property ((log_scale_en_in && module_intensity_value_reg[0] == 8'hff
                                        && channel_color_value_reg[0] == 8'h40) |-> duty_calc[0] == 12'h400)
    else $error("log curve touched colour");
  chk_module_share: assert property ((module_intensity_value_reg[1] == 8'h00 && !log_scale_en_in)
                                     |-> duty_calc[3] == {8'h00, channel_color_value_reg[3][7:4]})
    else $error("channel 3 not on module 1");
  chk_period_hold: assert property (enable_in && !period_end ##1 enable_in |-> $stable(duty_act_reg[0]))
    else $error("duty changed mid period");
  chk_lead_edge: assert property ((enable_in && cnt_reg == 9'h000 && g_ch[0].wid != 10'h000
                                   && state_reg != ST_SHUT) ##1 enable_in |-> sink_output_out[0])
    else $error("leading edge not at period start");
  chk_trail_edge: assert property ((enable_in && cnt_reg == PWM_LAST && g_ch[2].wid != 10'h000
                                    && state_reg != ST_SHUT) ##1 enable_in |-> sink_output_out[2])
    else $error("trailing edge not at period end");
  chk_zero_dark: assert property ((g_ch[1].wid == 10'h000) |=> !sink_output_out[1])
    else $error("zero duty produced a pulse");
  chk_tick_spacing: assert property ($rose(tick) |=> !tick [*7])
    else $error("oscillator tick spacing wrong");
  chk_psave_delay: assert property ($rose(power_save_out) |-> $past(off_done))
    else $error("power save without full deglitch");
  chk_iface_reset: assert property (!enable_in |=> iface_reset_out)
    else $error("interface reset late");
  chk_period_reload: assert property ((enable_in && period_end) ##1 enable_in
                                      |-> duty_act_reg[0] == $past(duty_calc[0]))
    else $error("duty not reloaded at period end");
  chk_addr_frozen: assert property ((enable_in && !iface_reset_out) ##1 enable_in
                                    |-> $stable(bus_address_out))
    else $error("bus address moved while enabled");
  chk_dither_off: assert property (!dither_en_in |-> g_ch[0].wid == {1'b0, duty_act_reg[0][11:3]})
    else $error("dither applied while disabled");

  cov_power_save: cover property ($rose(power_save_out));
  cov_period_wrap: cover property (period_end ##1 frame_reg == 3'h1);
  cov_dither_long: cover property (dither_en_in && g_ch[0].wid != {1'b0, duty_act_reg[0][11:3]});
  cov_log_mode: cover property (log_scale_en_in && reg_write_in && is_int);

endmodule : rcpd_dimmer_top
`default_nettype wire

// ### logic/rcpd_pkg.sv
// constants, types and helpers for the rgb channel pwm dimmer
// assumes a 125 MHz system clock and a decoded serial-bus register port
// ------------------------------------------------------------------
// Overview of operation
// - each output channel owns its own 8-bit colour value register
// - channels 3m, 3m+1, 3m+2 share module intensity register m
// - each module intensity register gives 256 distinct steps; log mode merges codes 0..15 into one step
// - intensity resets to ff, which applies full 100% factor
// - one global input selects logarithmic or linear intensity curve
// - curve applies to intensity only, never to the colour value
// - 12-bit duty per channel, period near 30.5 kHz
// - all-off condition must last about 30 ms before power save
// - serial interface held in reset within 3 us of enable falling
// - pwm timing derived from a nominal 15 MHz oscillator tick
// - two address pins sampled to form the bus address
// - final duty is colour value times module intensity
// - 9 bits pwm plus 3 bits dither, frac of every eight pulses longer
// - three phase groups: leading, centre, trailing edge fixed, cyclic
// ------------------------------------------------------------------
package rcpd_pkg;
  localparam int unsigned CLK_FREQ_HZ   = 125_000_000;
  localparam int unsigned OSC_FREQ_HZ   = 15_000_000;
  localparam int unsigned TICK_DIV      = (CLK_FREQ_HZ + OSC_FREQ_HZ / 2) / OSC_FREQ_HZ;
  localparam logic [3:0]  TICK_LAST     = 4'(TICK_DIV - 1);
  localparam int unsigned PSM_TIME_MS   = 30;
  localparam int unsigned PSM_CYCLES    = PSM_TIME_MS * (CLK_FREQ_HZ / 1000);
  localparam int unsigned EN_L_TIME_US  = 3;
  localparam int unsigned EN_L_CYCLES   = EN_L_TIME_US * (CLK_FREQ_HZ / 1_000_000);
  localparam int unsigned NUM_CH        = 12;
  localparam int unsigned NUM_MOD       = 4;
  localparam logic [8:0]  PWM_LAST      = 9'h1ff;
  localparam logic [9:0]  PWM_STEPS     = 10'h200;
  localparam logic [7:0]  INTENSITY_RST = 8'hff;
  localparam logic [7:0]  COLOR_RST     = 8'h00;
  localparam logic [4:0]  IDX_INT_BASE  = 5'h00;
  localparam logic [4:0]  IDX_COL_BASE  = 5'h04;
  localparam logic [4:0]  IDX_COL_END   = 5'h10;
  localparam logic [4:0]  IDX_STATUS    = 5'h10;
  localparam logic [4:0]  ADDR_BASE     = 5'h0a; // arbitrary value
  localparam logic [21:0] OFF_CNT_RST   = 22'h000000;

  typedef enum logic [2:0]
  {
    ST_SHUT   = 3'b001,
    ST_NORMAL = 3'b010,
    ST_PSAVE  = 3'b100
  } rcpd_state_type;

  // perceptual curve, (x*x + x) / 256, monotonic with fixed end points
  function automatic logic [7:0] rcpd_log_curve(input logic [7:0] x);
    logic [15:0] sq;
    sq = 16'({8'h00, x} * {8'h00, x}) + {8'h00, x};
    return sq[15:8];
  endfunction : rcpd_log_curve
endpackage : rcpd_pkg

// ### test/rcpd_host_model.sv
// host model: writes and reads the dimmer registers over the decoded port
// assumes the dimmer samples its register port on the rising clock edge
`timescale 1ns/10ps
`default_nettype none
module rcpd_host_model
#(
  parameter int unsigned WAKE_CYCLES = 16
)
(
  input  wire logic       clk_in,
  input  wire logic       enable_in,
  input  wire logic [7:0] rdata_in,
  output var  logic       write_out,
  output var  logic [4:0] index_out,
  output var  logic [7:0] wdata_out
);
  int unsigned awake_cnt = 0;
  int unsigned wait_fail = 0;

  // cycles since enable rose
  always @(posedge clk_in)
    awake_cnt <= enable_in ? awake_cnt + 1 : 0;

  // idle bus at time zero
  initial
  begin
    write_out = 1'b0;
    index_out = 5'h00;
    wdata_out = 8'h00;
  end

  // no access until the device is awake or 64 cycles have passed; a stuck wait is counted
  task automatic wait_awake();
    int unsigned n = 0;
    while (awake_cnt < WAKE_CYCLES && n < 64)
    begin
      @(posedge clk_in);
      n++;
    end
    if (awake_cnt < WAKE_CYCLES)
      wait_fail++;
  endtask : wait_awake

  // one write strobe
  task automatic put(input logic [4:0] idx, input logic [7:0] val);
    wait_awake();
    @(posedge clk_in);
    write_out <= 1'b1;
    index_out <= idx;
    wdata_out <= val;
    @(posedge clk_in);
    write_out <= 1'b0;
  endtask : put

  // present index, take the data latched one edge earlier
  task automatic get(input logic [4:0] idx, output logic [7:0] val);
    wait_awake();
    @(posedge clk_in);
    index_out <= idx;
    @(posedge clk_in);
    @(posedge clk_in);
    val = rdata_in;
  endtask : get
endmodule : rcpd_host_model
`default_nettype wire

// ### test/test_rcpd_dimmer_top.sv
// testbench for the rgb channel pwm dimmer
// assumes the host model drives the register port
`timescale 1ns/10ps
`default_nettype none
module test_rcpd_dimmer_top
  import rcpd_pkg::*;
;
  logic        clk_sys = 1'b0;
  logic        reset_n = 1'b0;
  logic        enable = 1'b0;
  logic        log_en = 1'b0;
  logic        dither_en = 1'b0;
  logic        psave_en = 1'b0;
  logic [1:0]  pins = 2'h2;
  logic        wr;
  logic [4:0]  idx;
  logic [7:0]  wdata, rdata, rd;
  logic [11:0] sink;
  logic [6:0]  bus_addr;
  logic        ifr, psave;
  int unsigned n_errors = 0, check_count = 0, n;
  logic [31:0] hi [12];
  logic [31:0] ov;
  logic [7:0]  col [12] = '{default: 8'h00};
  logic [7:0]  inten [4] = '{default: 8'hff};

  always #4 clk_sys = ~clk_sys;

  rcpd_dimmer_top #(.PSM_DEGLITCH_CYCLES(50)) rcpd_dimmer_top_inst (
    .clk_sys_in(clk_sys), .reset_n_in(reset_n), .enable_in(enable),
    .hw_address_pins_in(pins), .log_scale_en_in(log_en),
    .dither_en_in(dither_en), .power_save_en_in(psave_en),
    .reg_write_in(wr), .reg_index_in(idx), .reg_wdata_in(wdata),
    .sink_output_out(sink), .reg_rdata_out(rdata),
    .bus_address_out(bus_addr), .iface_reset_out(ifr),
    .power_save_out(psave));

  rcpd_host_model rcpd_host_model_inst (
    .clk_in(clk_sys), .enable_in(enable), .rdata_in(rdata),
    .write_out(wr), .index_out(idx), .wdata_out(wdata));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic finish_test();
    n_errors += rcpd_host_model_inst.wait_fail;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : finish_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // write through the host and track expected contents
  task automatic wr_reg(input logic [4:0] i, input logic [7:0] v);
    rcpd_host_model_inst.put(i, v);
    if (i < 5'h04)
      inten[i[1:0]] = v;
    else if (i < 5'h10)
      col[i - 5'h04] = v;
  endtask : wr_reg

  // high clocks per channel and phase overlaps over n cycles
  task automatic measure(input int unsigned cyc);
    ov = 0;
    for (int c = 0; c < 12; c++) hi[c] = 0;
    repeat (cyc)
    begin
      @(posedge clk_sys);
      #1;
      ov += (sink[0] & sink[1]) | (sink[1] & sink[2]) | (sink[0] & sink[2]);
      for (int c = 0; c < 12; c++) hi[c] += sink[c];
    end
  endtask : measure

  // high clocks in one period, dither off
  function automatic logic [31:0] exp_clk(input logic [7:0] c, input logic [7:0] i, input logic lg);
    logic [15:0] f;
    logic [15:0] d;
    f = lg ? ((16'(i) * i + i) >> 8) : 16'(i);
    d = (16'(c) * (f + 16'h0001)) >> 4;
    return 32'(d[11:3]) * 8;
  endfunction : exp_clk

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_regs();
    for (int m = 0; m < 4; m++)
    begin
      rcpd_host_model_inst.get(5'(m), rd);
      check(rd, 8'hff);
    end
    wr_reg(5'h09, 8'h5a);
    wr_reg(5'h01, 8'h3c);
    wr_reg(5'h11, 8'h77);
    wr_reg(5'h10, 8'hff);
    rcpd_host_model_inst.get(5'h09, rd);
    check(rd, 8'h5a);
    rcpd_host_model_inst.get(5'h01, rd);
    check(rd, 8'h3c);
    wr_reg(5'h01, 8'h00);
    wr_reg(5'h07, 8'hc3);
    rcpd_host_model_inst.get(5'h11, rd);
    check(rd, 8'h00);
    rcpd_host_model_inst.get(5'h10, rd);
    check(rd, 8'h01);
  endtask : t_regs

  task automatic t_pwm(input logic lg);
    @(posedge clk_sys);
    log_en <= lg;
    repeat (8200) @(posedge clk_sys);
    measure(4096);
    for (int c = 0; c < 12; c++)
      check(hi[c], exp_clk(col[c], inten[c / 3], lg));
  endtask : t_pwm

  task automatic t_phase();
    for (int c = 0; c < 3; c++) wr_reg(5'(c + 4), 8'h40);
    wr_reg(5'h00, 8'hff);
    repeat (8200) @(posedge clk_sys);
    measure(4096);
    check(hi[1], 32'd1024);
    check(ov, 32'd0);
  endtask : t_phase

  task automatic t_dither();
    wr_reg(5'h00, 8'h0f);
    wr_reg(5'h04, 8'h0b);
    dither_en <= 1'b1;
    repeat (8200) @(posedge clk_sys);
    measure(32768);
    check(hi[0], 32'd88);
  endtask : t_dither

  task automatic t_psave();
    for (int c = 4; c < 16; c++) wr_reg(5'(c), 8'h00);
    psave_en <= 1'b1;
    for (n = 0; n < 9000 && psave !== 1'b1; n++)
    begin
      @(posedge clk_sys);
      #1;
    end
    check(psave, 1'b1);
    if (n == 9000)
      finish_test();
    rcpd_host_model_inst.get(5'h10, rd);
    check(rd, 8'h02);
    wr_reg(5'h04, 8'h01);
    @(posedge clk_sys);
    #1;
    check(psave, 1'b0);
  endtask : t_psave

  task automatic t_enable();
    check(bus_addr, {ADDR_BASE, 2'h2});
    @(posedge clk_sys);
    enable <= 1'b0;
    pins <= 2'h1;
    for (n = 0; n < EN_L_CYCLES && ifr !== 1'b1; n++)
    begin
      @(posedge clk_sys);
      #1;
    end
    check(ifr, 1'b1);
    if (n == EN_L_CYCLES)
      finish_test();
    repeat (2) @(posedge clk_sys);
    #1;
    check(bus_addr, {ADDR_BASE, 2'h1});
    @(posedge clk_sys);
    enable <= 1'b1;
    @(posedge clk_sys);
    pins <= 2'h3;
    #1;
    check(ifr, 1'b0);
    rcpd_host_model_inst.get(5'h00, rd);
    check(rd, 8'hff);
    rcpd_host_model_inst.get(5'h04, rd);
    check(rd, 8'h00);
    check(bus_addr, {ADDR_BASE, 2'h1});
  endtask : t_enable

  // main sequence
  initial
  begin
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    enable <= 1'b1;
    t_regs();
    wr_reg(5'h04, 8'hff);
    wr_reg(5'h05, 8'h80);
    wr_reg(5'h06, 8'h10);
    wr_reg(5'h00, 8'h80);
    t_pwm(1'b0);
    t_pwm(1'b1);
    t_phase();
    @(posedge clk_sys);
    log_en <= 1'b0;
    for (int c = 5; c < 7; c++) wr_reg(5'(c), 8'h00);
    t_dither();
    t_psave();
    t_enable();
    finish_test();
  end
endmodule : test_rcpd_dimmer_top
`default_nettype wire
